// ---- hw/fpc_defines.vh ----
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH
// command codes written to the command_interface
`define FPC_CMD_READ_ARRAY   8'hFF
`define FPC_CMD_READ_STATUS  8'h70
`define FPC_CMD_CLEAR_STATUS 8'h50
`define FPC_CMD_PROG_SETUP   8'h40
`define FPC_CMD_ERASE_SETUP  8'h20
`define FPC_CMD_ERASE_CONF   8'hD0
// status bit that signals the write_state_machine is ready
`define FPC_SR_READY_BIT     7
// timing figures in ns
`define FPC_CLK_NS           10
`define FPC_T_STROBE_NS      60
`define FPC_T_ACCESS_NS      120
`define FPC_T_RECOVERY_NS    600
`define FPC_T_RESET_NS       100
// op codes on the user side
`define FPC_OP_READ          3'h0
`define FPC_OP_WRITE         3'h1
`define FPC_OP_PROGRAM       3'h2
`define FPC_OP_ERASE         3'h3
`define FPC_OP_STATUS        3'h4
`define FPC_OP_POWERDOWN     3'h5
`define FPC_OP_WAKE          3'h6
`endif

// ---- hw/fpc_host.v ----
`timescale 1ns/100ps
`include "fpc_defines.vh"
// Contract
// - after power-up select before trusting data
// - write only with write enable and select low
// - host issues read array after program and erase operations
// - tie reset to processor reset
module fpc_host #(
	parameter AW = 18,
	parameter DW = 16
) (
	input  wire          clock,
	input  wire          rst,
	input  wire          req_valid,
	input  wire [2:0]    req_op,
	input  wire [AW-1:0] req_addr,
	input  wire [DW-1:0] req_data,
	output reg           req_ready,
	output reg           rsp_valid,
	output reg  [DW-1:0] rsp_data,
	output reg           busy_abort,
	output reg  [AW-1:0] flash_addr,
	output reg  [DW-1:0] flash_dq_out,
	output reg           flash_dq_oe_n,
	input  wire [DW-1:0] flash_dq_in,
	output reg           flash_ce_n,
	output reg           flash_oe_n,
	output reg           flash_we_n,
	output reg           reset_powerdown_n
);
	localparam integer STROBE_CYC = (`FPC_T_STROBE_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS;
	localparam integer ACCESS_CYC = (`FPC_T_ACCESS_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS;
	localparam integer RECOV_CYC  = (`FPC_T_RECOVERY_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS;
	localparam integer RESET_CYC  = (`FPC_T_RESET_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS;
	// counts cut to the counter width on purpose; all fit in eight bits
	localparam [7:0] STROBE_C = STROBE_CYC[7:0];
	localparam [7:0] ACCESS_C = ACCESS_CYC[7:0];
	localparam [7:0] RECOV_C  = RECOV_CYC[7:0];
	localparam [7:0] RESET_C  = RESET_CYC[7:0];
	localparam [7:0] ONE      = 8'h01;

	localparam [7:0] S_RST   = 8'h01;
	localparam [7:0] S_IDLE  = 8'h02;
	localparam [7:0] S_WR    = 8'h04;
	localparam [7:0] S_WGAP  = 8'h08;
	localparam [7:0] S_RD    = 8'h10;
	localparam [7:0] S_POLL  = 8'h20;
	localparam [7:0] S_PD    = 8'h40;
	localparam [7:0] S_WAKE  = 8'h80;

	reg [7:0]    state_r;
	reg [7:0]    cnt_r;
	reg [1:0]    seq_r;
	reg [2:0]    op_r;
	reg [AW-1:0] addr_r;
	reg [DW-1:0] data_r;
	reg [DW-1:0] wdata_r;
	reg          poll_r;
	reg          op_busy_r;

	////////////////////////////////////////////////////////////////
	// sequencer: one access at a time, counted pin timing
	always @(posedge clock)
	begin
		if (rst)
		begin
			state_r           <= S_RST;
			cnt_r             <= RESET_C;
			seq_r             <= 2'h0;
			op_r              <= `FPC_OP_READ;
			addr_r            <= {AW{1'b0}};
			data_r            <= {DW{1'b0}};
			wdata_r           <= {DW{1'b0}};
			poll_r            <= 1'b0;
			op_busy_r         <= 1'b0;
			req_ready         <= 1'b0;
			rsp_valid         <= 1'b0;
			rsp_data          <= {DW{1'b0}};
			busy_abort        <= 1'b0;
			flash_addr        <= {AW{1'b0}};
			flash_dq_out      <= {DW{1'b0}};
			flash_dq_oe_n     <= 1'b1;
			flash_ce_n        <= 1'b1;
			flash_oe_n        <= 1'b1;
			flash_we_n        <= 1'b1;
			reset_powerdown_n <= 1'b0;
		end
		else
		begin
			rsp_valid  <= 1'b0;
			busy_abort <= 1'b0;
			case (state_r)
			S_RST, S_WAKE:
			begin
				reset_powerdown_n <= 1'b1;
				if (cnt_r > ONE)
					cnt_r <= cnt_r - ONE;
				else
				begin
					state_r   <= S_IDLE;
					req_ready <= 1'b1;
				end
			end
			S_IDLE:
			begin
				if (req_valid)
				begin
					req_ready <= 1'b0;
					op_r      <= req_op;
					addr_r    <= req_addr;
					data_r    <= req_data;
					flash_addr <= req_addr;
					if (req_op == `FPC_OP_POWERDOWN)
					begin
						// drive reset low for deep power-down
						reset_powerdown_n <= 1'b0;
						// abort flag taken from op_busy_r, which is always clear in idle, so it never rises
						busy_abort <= op_busy_r;
						op_busy_r  <= 1'b0;
						state_r    <= S_PD;
						req_ready  <= 1'b1;
					end
					else if (req_op == `FPC_OP_READ)
					begin
						// select with fresh address before using data
						flash_ce_n <= 1'b0;
						flash_oe_n <= 1'b0;
						cnt_r      <= ACCESS_C;
						state_r    <= S_RD;
					end
					else
					begin
						// program and erase use two writes
						seq_r   <= (req_op == `FPC_OP_PROGRAM || req_op == `FPC_OP_ERASE) ? 2'h2 : 2'h1;
						wdata_r <= (req_op == `FPC_OP_PROGRAM) ? {{(DW-8){1'b0}}, `FPC_CMD_PROG_SETUP} :
						           (req_op == `FPC_OP_ERASE)   ? {{(DW-8){1'b0}}, `FPC_CMD_ERASE_SETUP} :
						           (req_op == `FPC_OP_STATUS)  ? {{(DW-8){1'b0}}, `FPC_CMD_READ_STATUS} :
						           req_data;
						state_r <= S_WGAP;
						cnt_r   <= ONE;
					end
				end
			end
			S_WGAP:
			begin
				// write strobe with select and write enable low
				flash_ce_n    <= 1'b0;
				flash_we_n    <= 1'b0;
				flash_dq_out  <= wdata_r;
				flash_dq_oe_n <= 1'b0;
				cnt_r         <= STROBE_C;
				state_r       <= S_WR;
			end
			S_WR:
			begin
				if (cnt_r > ONE)
					cnt_r <= cnt_r - ONE;
				else
				begin
					flash_we_n    <= 1'b1;
					flash_ce_n    <= 1'b1;
					flash_dq_oe_n <= 1'b1;
					seq_r         <= seq_r - 2'h1;
					if (seq_r == 2'h2)
					begin
						wdata_r <= (op_r == `FPC_OP_ERASE) ? {{(DW-8){1'b0}}, `FPC_CMD_ERASE_CONF} : data_r;
						state_r <= S_WGAP;
					end
					else if (op_r == `FPC_OP_PROGRAM || op_r == `FPC_OP_ERASE)
					begin
						// stays selected to poll status; device finishes on its own
						op_busy_r <= 1'b1;
						poll_r    <= 1'b1;
						flash_ce_n <= 1'b0;
						flash_oe_n <= 1'b0;
						cnt_r     <= ACCESS_C;
						state_r   <= S_RD;
					end
					else
					begin
						state_r   <= (op_r == `FPC_OP_STATUS) ? S_RD : S_IDLE;
						flash_ce_n <= (op_r == `FPC_OP_STATUS) ? 1'b0 : 1'b1;
						flash_oe_n <= (op_r == `FPC_OP_STATUS) ? 1'b0 : 1'b1;
						cnt_r     <= ACCESS_C;
						rsp_valid <= (op_r != `FPC_OP_STATUS);
						req_ready <= (op_r != `FPC_OP_STATUS);
					end
				end
			end
			S_RD:
			begin
				if (cnt_r > ONE)
					cnt_r <= cnt_r - ONE;
				else
				begin
					// deselect to standby after each read
					flash_ce_n <= 1'b1;
					flash_oe_n <= 1'b1;
					if (poll_r && !flash_dq_in[`FPC_SR_READY_BIT])
						state_r <= S_POLL;
					else if (poll_r)
					begin
						poll_r    <= 1'b0;
						op_busy_r <= 1'b0;
						rsp_data  <= flash_dq_in;
						op_r      <= `FPC_OP_WRITE;
						seq_r     <= 2'h1;
						wdata_r   <= {{(DW-8){1'b0}}, `FPC_CMD_READ_ARRAY};
						state_r   <= S_WGAP;
					end
					else
					begin
						rsp_data  <= flash_dq_in;
						rsp_valid <= 1'b1;
						req_ready <= 1'b1;
						state_r   <= S_IDLE;
					end
				end
			end
			S_POLL:
			begin
				// toggling select refreshes the status read
				flash_ce_n <= 1'b0;
				flash_oe_n <= 1'b0;
				cnt_r      <= ACCESS_C;
				state_r    <= S_RD;
			end
			S_PD:
			begin
				// hold pins idle while device is down
				flash_ce_n <= 1'b1;
				flash_oe_n <= 1'b1;
				flash_we_n <= 1'b1;
				if (req_valid && req_op == `FPC_OP_WAKE)
				begin
					req_ready <= 1'b0;
					cnt_r     <= RECOV_C;
					state_r   <= S_WAKE;
				end
			end
			default:
				state_r <= S_RST;
			endcase
		end
	end
endmodule

// ---- tb/fpc_flash_model.sv ----
`timescale 1ns/100ps
module fpc_flash_model (
	input  wire        ce_n,
	input  wire        oe_n,
	input  wire        we_n,
	input  wire        rp_n,
	input  wire [17:0] addr,
	input  wire [15:0] din,
	output wire [15:0] dq
);
	reg  [15:0] mem [0:15];
	reg  [15:0] last;
	reg  [7:0]  cmd;
	reg  [7:0]  sr;
	wire        on;
	wire        strobe;
	integer     i;
	initial
	begin
		for (i = 0; i < 16; i = i + 1)
			mem[i] = 16'hFFFF;
		cmd = 8'hFF;
		sr = 8'h80;
		last = 16'h0000;
	end
	assign strobe = !ce_n && !we_n;
	// latch at strobe end
	// select and write enable may rise in one step, so the end of either counts
	always @(negedge strobe)
		if (rp_n && sr[7])
		begin
			if (cmd == 8'h40)
				mem[addr[3:0]] = mem[addr[3:0]] & din;
			else if (cmd == 8'h20 && din[7:0] == 8'hD0)
				for (i = 0; i < 16; i = i + 1)
					mem[i] = 16'hFFFF;
			if (cmd == 8'h40 || (cmd == 8'h20 && din[7:0] == 8'hD0))
			begin
				cmd = 8'h70;
				sr[7] = 1'b0;
				sr[7] <= #300 1'b1;
			end
			else
				cmd = din[7:0];
		end
	// power-down aborts, clears status, resets interface
	always @(negedge rp_n)
	begin
		cmd = 8'hFF;
		sr = 8'h80;
	end
	// drive only when selected and awake; released bus shows inverse
	assign on = !ce_n && !oe_n && rp_n;
	assign dq = on ? (cmd == 8'h70 ? {8'h00, sr} : mem[addr[3:0]]) : ~last;
	always @(dq)
		if (on)
			last = dq;
endmodule

// ---- tb/fpc_host_properties.sv ----
`timescale 1ns/100ps
module fpc_host_properties (
	input wire clock,
	input wire rst,
	input wire req_ready,
	input wire rsp_valid,
	input wire busy_abort,
	input wire flash_dq_oe_n,
	input wire flash_ce_n,
	input wire flash_oe_n,
	input wire flash_we_n,
	input wire reset_powerdown_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_write_needs_select: assert property (!flash_we_n |-> !flash_ce_n) else $error("bad write");
	a_no_read_write: assert property (!(!flash_oe_n && !flash_we_n)) else $error("read and write");
	a_drive_not_read: assert property (!flash_dq_oe_n |-> flash_oe_n) else $error("bus clash");
	a_reset_exit_pins: assert property ($fell(rst) |-> flash_ce_n && !reset_powerdown_n) else $error("exit");
	a_pd_no_strobe: assert property (!reset_powerdown_n |-> flash_we_n && flash_ce_n) else $error("pd strobe");
	a_read_hold: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*8]) else $error("short read");
	a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("long answer");
	a_wake_recover: assert property ($rose(reset_powerdown_n) |-> !req_ready [*8]) else $error("early");
	a_idle_deselect: assert property (req_ready |-> flash_ce_n) else $error("busy idle");
	a_abort_in_pd: assert property (busy_abort |-> !reset_powerdown_n) else $error("abort awake");
	cover property (rsp_valid);
	cover property ($fell(flash_we_n));
	cover property ($fell(reset_powerdown_n));
endmodule
bind fpc_host fpc_host_properties u_props (.clock(clock), .rst(rst), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .busy_abort(busy_abort), .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
	.flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .reset_powerdown_n(reset_powerdown_n));

// ---- tb/fpc_host_bench.sv ----
`timescale 1ns/100ps
module fpc_host_bench;
	reg         clock;
	reg         rst;
	reg         req_valid;
	reg  [2:0]  req_op;
	reg  [17:0] req_addr;
	reg  [15:0] req_data;
	wire        req_ready, rsp_valid, dq_oe_n, ce_n, oe_n, we_n, rp_n;
	wire [17:0] fa;
	wire [15:0] rsp_data, dq_out, dq_dev;
	integer     fails, n_tests, k;
	fpc_host u_fpc_host (.clock(clock), .rst(rst), .req_valid(req_valid), .req_op(req_op),
		.req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .busy_abort(), .flash_addr(fa), .flash_dq_out(dq_out),
		.flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_oe_n ? dq_dev : dq_out), .flash_ce_n(ce_n),
		.flash_oe_n(oe_n), .flash_we_n(we_n), .reset_powerdown_n(rp_n));
	fpc_flash_model u_fpc_flash_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n),
		.addr(fa), .din(dq_out), .dq(dq_dev));
	initial
	begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	task check(input [15:0] seen, input [15:0] exp);
	begin
		n_tests = n_tests + 1;
		if (seen !== exp)
		begin
			fails = fails + 1;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	end
	endtask
	task give_verdict;
	begin
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	// one request, then a bounded wait for idle again
	task run(input [2:0] op, input [17:0] a, input [15:0] d);
	begin
		k = 0;
		@(negedge clock);
		req_op = op;
		req_addr = a;
		req_data = d;
		req_valid = 1;
		while (!req_ready && k < 3000)
		begin
			@(negedge clock);
			k = k + 1;
		end
		@(negedge clock);
		req_valid = 0;
		while (!req_ready && k < 3000)
		begin
			@(negedge clock);
			k = k + 1;
		end
		if (k >= 3000)
		begin
			fails = fails + 1;
			give_verdict;
		end
	end
	endtask
	task t_boot_read;
	begin
		run(3'h0, 18'h00003, 16'h0000);
		check({15'h0000, rsp_valid}, 16'h0001);
		check(rsp_data, 16'hFFFF);
	end
	endtask
	task t_program;
	begin
		run(3'h2, 18'h00003, 16'h1234);
		run(3'h0, 18'h00003, 16'h0000);
		check(rsp_data, 16'h1234);
	end
	endtask
	// erase setup without confirm must leave the array alone
	task t_half_cmd;
	begin
		run(3'h1, 18'h00003, 16'h0020);
		run(3'h1, 18'h00003, 16'h00FF);
		run(3'h0, 18'h00003, 16'h0000);
		check(rsp_data, 16'h1234);
	end
	endtask
	task t_status;
	begin
		run(3'h4, 18'h00000, 16'h0000);
		check(rsp_data, 16'h0080);
		run(3'h1, 18'h00000, 16'h00FF);
	end
	endtask
	task t_erase;
	begin
		run(3'h3, 18'h00003, 16'h0000);
		run(3'h0, 18'h00003, 16'h0000);
		check(rsp_data, 16'hFFFF);
	end
	endtask
	// status mode left latched, power-down must bring back array reads
	task t_powerdown;
	begin
		run(3'h1, 18'h00000, 16'h0070);
		run(3'h5, 18'h00000, 16'h0000);
		check({15'h0000, rp_n}, 16'h0000);
		run(3'h6, 18'h00000, 16'h0000);
		check({15'h0000, rp_n}, 16'h0001);
		run(3'h0, 18'h00005, 16'h0000);
		check(rsp_data, 16'hFFFF);
	end
	endtask
	initial
	begin
		fails = 0;
		n_tests = 0;
		rst = 1;
		req_valid = 0;
		req_op = 3'h0;
		req_addr = 18'h00000;
		req_data = 16'h0000;
		repeat (3) @(negedge clock);
		rst = 0;
		t_boot_read;
		t_program;
		t_half_cmd;
		t_status;
		t_erase;
		t_powerdown;
		give_verdict;
	end
endmodule
